// ---- design/core_pkg.sv ----
/*
 Shared constants, operation codes and result type of the instruction
 decode and execute block. Assumes nothing of its surroundings.
*/
`default_nettype none
package core_pkg;
   localparam int INSTR_W = 14;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int PC_W = 13;
   localparam int FILE_DEPTH = 128;
   ////////////////////////////////////////////////////////////////////////////
   // Instruction field positions
   localparam int GRP_LSB = 12;
   localparam int SUB_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int BITNUM_LSB = 7;
   localparam int BITNUM_W = 3;
   localparam int K8_W = 8;
   localparam int K11_W = 11;
   localparam int LATCH_HI_W = PC_W - DATA_W;
   localparam int LATCH_PAGE_LSB = 3;
   localparam int PAGE_W = PC_W - K11_W;
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: four oscillator periods per instruction cycle
   localparam logic [1:0] Q_LAST = 2'h3;
   ////////////////////////////////////////////////////////////////////////////
   // Special function register addresses and status bits
   localparam logic [ADDR_W-1:0] SFR_PC_LOW = 7'h02;
   localparam logic [ADDR_W-1:0] SFR_STATUS = 7'h03;
   localparam logic [ADDR_W-1:0] SFR_PORT_DIR = 7'h06;
   localparam logic [ADDR_W-1:0] SFR_PC_LATCH = 7'h0a;
   localparam int STAT_C = 0;
   localparam int STAT_DCARRY = 1;
   localparam int STAT_Z = 2;
   localparam logic [DATA_W-1:0] PORT_DIR_FIXED = 8'h08;
   localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
   localparam logic [DATA_W-1:0] PC_LATCH_RST = 8'h00;
   localparam logic [DATA_W-1:0] PORT_DIR_RST = 8'hff;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   ////////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [11:0] REG_INSTR = 12'h000;
   localparam logic [11:0] REG_CORE = 12'h004;
   localparam logic [11:0] REG_ACC = 12'h008;
   localparam logic [11:0] REG_PC = 12'h00c;
   localparam logic [11:0] REG_STATUS = 12'h010;
   localparam logic [11:0] REG_PC_LATCH = 12'h014;
   localparam logic [11:0] REG_PORT_DIR = 12'h018;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [4:0] {
      OP_NOP, OP_MOVWF, OP_CLEAR, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF,
      OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ, OP_RRF,
      OP_RLF, OP_SWAPF, OP_INCFSZ, OP_BIT_CLR, OP_BIT_SET, OP_TEST_CLR,
      OP_TEST_SET, OP_CALL, OP_GOTO, OP_MOVLW, OP_RETLW, OP_IORLW,
      OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW
   } op_e;
   typedef struct packed {
      logic [DATA_W-1:0] res;
      logic z;
      logic dcarry;
      logic c;
   } alu_s;
endpackage
`default_nettype wire

// ---- design/decode_if.sv ----
/*
 Carries the instruction word to the decoder and its fields back.
 Assumes the core drives instr and the decoder drives the rest.
*/
`default_nettype none
interface decode_if
   import core_pkg::*;
();
   logic [INSTR_W-1:0] instr;
   op_e op;
   logic dest;
   logic [ADDR_W-1:0] faddr;
   logic [BITNUM_W-1:0] bitn;
   logic [K8_W-1:0] k8;
   logic [K11_W-1:0] k11;
   modport dec (input instr, output op, dest, faddr, bitn, k8, k11);
   modport core (output instr, input op, dest, faddr, bitn, k8, k11);
endinterface
`default_nettype wire

// ---- design/file_ram.sv ----
/*
 General file register storage: one write port, one registered read.
 Assumes write and read addresses stay inside DEPTH.
*/
`default_nettype none
module file_ram #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata_q
);
   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("file_ram: DEPTH or WIDTH out of range");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   ////////////////////////////////////////////////////////////////////////////
   // Array content has no reset, like real storage
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

// ---- design/instr_decoder.sv ----
/*
 Splits a 14-bit instruction into operation and operand fields.
 Assumes the core holds instr stable for a whole instruction cycle.
*/
`default_nettype none
module instr_decoder
   import core_pkg::*;
(
   decode_if.dec dif
);
   logic [1:0] grp;
   logic [3:0] sub;
   assign grp = dif.instr[GRP_LSB +: 2];
   assign sub = dif.instr[SUB_LSB +: 4];
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      dif.dest = dif.instr[DEST_BIT];
      dif.faddr = dif.instr[ADDR_W-1:0];
      dif.bitn = dif.instr[BITNUM_LSB +: BITNUM_W];
      dif.k8 = dif.instr[K8_W-1:0];
      dif.k11 = dif.instr[K11_W-1:0];
      // Unlisted control words fall to no-operation; free bits unread
      unique case (grp)
         2'h0: begin
            unique case (sub)
               4'h0: dif.op = dif.instr[DEST_BIT] ? OP_MOVWF : OP_NOP;
               4'h1: dif.op = OP_CLEAR;
               4'h2: dif.op = OP_SUBWF;
               4'h3: dif.op = OP_DECF;
               4'h4: dif.op = OP_IORWF;
               4'h5: dif.op = OP_ANDWF;
               4'h6: dif.op = OP_XORWF;
               4'h7: dif.op = OP_ADDWF;
               4'h8: dif.op = OP_MOVF;
               4'h9: dif.op = OP_COMF;
               4'ha: dif.op = OP_INCF;
               4'hb: dif.op = OP_DECFSZ;
               4'hc: dif.op = OP_RRF;
               4'hd: dif.op = OP_RLF;
               4'he: dif.op = OP_SWAPF;
               4'hf: dif.op = OP_INCFSZ;
            endcase
         end
         2'h1: begin
            unique case (sub[3:2])
               2'h0: dif.op = OP_BIT_CLR;
               2'h1: dif.op = OP_BIT_SET;
               2'h2: dif.op = OP_TEST_CLR;
               2'h3: dif.op = OP_TEST_SET;
            endcase
         end
         2'h2: dif.op = sub[3] ? OP_GOTO : OP_CALL;
         2'h3: begin
            unique case (sub[3:2])
               2'h0: dif.op = OP_MOVLW;
               2'h1: dif.op = OP_RETLW;
               2'h2: begin
                  unique case (sub[1:0])
                     2'h0: dif.op = OP_IORLW;
                     2'h1: dif.op = OP_ANDLW;
                     2'h2: dif.op = OP_XORLW;
                     2'h3: dif.op = OP_NOP;
                  endcase
               end
               2'h3: dif.op = sub[1] ? OP_ADDLW : OP_SUBLW;
            endcase
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- design/instr_format_decode_exec.sv ----
/*
 Instruction sequencer and executor of a small 8-bit core, fed and
 observed over APB. Assumes one clock pclk and an APB master that holds
 each request until pready.
*/
//
// How it works
// - Instructions are taken and decoded as whole 14-bit words.
// - Byte ops: opcode 13..8, destination bit 7, file address 6..0.
// - Destination zero writes the accumulator, one writes the file.
// - Bit ops: bit number in 9..7, file address in 6..0.
// - Literals use bits 7..0; call and goto use 11 bits 10..0.
// - Addresses 0x00 to 0x7F reach every file register, SFRs too.
// - One cycle normally; skips and program counter changes add a nop.
// - Each instruction cycle lasts exactly four clock periods.
// - Free encoding bits are ignored whatever they hold.
// - Flags made by an op override bits written into status.
// - Port direction bit 3 always reads one, also inside RMW.
// - Program counter low reads directly; writing it also loads bits 12..8 from latch bits 4..0.
// - Bit ops read the whole byte, change one bit, write all back.
// - Goto loads 11 literal bits plus latch bits 4..3, two cycles.
`default_nettype none
module instr_format_decode_exec
   import core_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} seq_e;

   seq_e state_q, state_d;
   logic [1:0] q_q, q_d;
   logic [INSTR_W-1:0] ir_q, ir_d, pend_ir_q, pend_ir_d;
   logic pend_q, pend_d;
   logic [DATA_W-1:0] acc_q, acc_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [DATA_W-1:0] status_q, status_d;
   logic [DATA_W-1:0] pc_latch_q, pc_latch_d;
   logic [DATA_W-1:0] pdir_q, pdir_d;
   logic [31:0] prdata_q, prdata_d;
   logic [DATA_W-1:0] ram_rdata, src;
   logic mem_we, file_wr, acc_wr, two_cycle, skip, mapped, instr_wr;
   logic [2:0] flag_use;
   alu_s alu;

   decode_if dif ();
   assign dif.instr = ir_q;

   instr_decoder u_dec (
      .dif(dif)
   );

   file_ram #(.DEPTH(FILE_DEPTH), .WIDTH(DATA_W)) u_ram (
      .clk(pclk),
      .rst_n(presetn),
      .we(mem_we),
      .waddr(dif.faddr),
      .wdata(alu.res),
      .raddr(dif.faddr),
      .rdata_q(ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers
   function automatic alu_s add8(input logic [DATA_W-1:0] x,
                                 input logic [DATA_W-1:0] y,
                                 input logic cin);
      logic [DATA_W:0] s;
      logic [4:0] n;
      alu_s r;
      s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      r.res = s[DATA_W-1:0];
      r.c = s[DATA_W];
      r.dcarry = n[4];
      r.z = 1'b0;
      return r;
   endfunction

   function automatic logic is_byte_op(input op_e op);
      return op inside {OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF, OP_XORWF,
                        OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ,
                        OP_RRF, OP_RLF, OP_SWAPF, OP_INCFSZ, OP_CLEAR};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Source byte; SFRs come from their own flops
   always_comb begin
      unique case (dif.faddr)
         SFR_PC_LOW: src = pc_q[DATA_W-1:0];
         SFR_STATUS: src = status_q;
         SFR_PC_LATCH: src = pc_latch_q;
         SFR_PORT_DIR: src = pdir_q | PORT_DIR_FIXED;
         default: src = ram_rdata;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operation result, flags it owns, destinations and cycle count
   always_comb begin
      logic [DATA_W-1:0] mask;
      mask = 8'h01 << dif.bitn;
      alu = '0;
      flag_use = 3'h0;
      skip = 1'b0;
      unique case (dif.op)
         OP_NOP: alu.res = acc_q;
         OP_MOVWF: alu.res = acc_q;
         OP_CLEAR: alu.res = 8'h00;
         OP_SUBWF: alu = add8(src, ~acc_q, 1'b1);
         OP_DECF: alu.res = src - 8'h01;
         OP_IORWF: alu.res = src | acc_q;
         OP_ANDWF: alu.res = src & acc_q;
         OP_XORWF: alu.res = src ^ acc_q;
         OP_ADDWF: alu = add8(src, acc_q, 1'b0);
         OP_MOVF: alu.res = src;
         OP_COMF: alu.res = ~src;
         OP_INCF: alu.res = src + 8'h01;
         OP_DECFSZ: alu.res = src - 8'h01;
         OP_RRF: begin
            alu.res = {status_q[STAT_C], src[DATA_W-1:1]};
            alu.c = src[0];
         end
         OP_RLF: begin
            alu.res = {src[DATA_W-2:0], status_q[STAT_C]};
            alu.c = src[DATA_W-1];
         end
         OP_SWAPF: alu.res = {src[3:0], src[7:4]};
         OP_INCFSZ: alu.res = src + 8'h01;
         OP_BIT_CLR: alu.res = src & ~mask;
         OP_BIT_SET: alu.res = src | mask;
         OP_TEST_CLR: begin
            alu.res = src;
            skip = ~|(src & mask);
         end
         OP_TEST_SET: begin
            alu.res = src;
            skip = |(src & mask);
         end
         OP_CALL: alu.res = acc_q;
         OP_GOTO: alu.res = acc_q;
         OP_MOVLW: alu.res = dif.k8;
         OP_RETLW: alu.res = dif.k8;
         OP_IORLW: alu.res = dif.k8 | acc_q;
         OP_ANDLW: alu.res = dif.k8 & acc_q;
         OP_XORLW: alu.res = dif.k8 ^ acc_q;
         OP_SUBLW: alu = add8(dif.k8, ~acc_q, 1'b1);
         OP_ADDLW: alu = add8(dif.k8, acc_q, 1'b0);
      endcase
      alu.z = (alu.res == 8'h00);
      if (dif.op inside {OP_DECFSZ, OP_INCFSZ}) begin
         skip = alu.z;
      end
      // Bit order {z, dc, c}
      if (dif.op inside {OP_SUBWF, OP_ADDWF, OP_SUBLW, OP_ADDLW}) begin
         flag_use = 3'h7;
      end else if (dif.op inside {OP_RRF, OP_RLF}) begin
         flag_use = 3'h1;
      end else if (dif.op inside {OP_CLEAR, OP_DECF, OP_IORWF, OP_ANDWF,
                                  OP_XORWF, OP_MOVF, OP_COMF, OP_INCF,
                                  OP_IORLW, OP_ANDLW, OP_XORLW}) begin
         flag_use = 3'h4;
      end
      if (is_byte_op(dif.op)) begin
         file_wr = dif.dest;
         acc_wr = ~dif.dest;
      end else begin
         file_wr = dif.op inside {OP_MOVWF, OP_BIT_CLR, OP_BIT_SET,
                                  OP_TEST_CLR, OP_TEST_SET};
         acc_wr = dif.op inside {OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW,
                                 OP_XORLW, OP_SUBLW, OP_ADDLW};
      end
      two_cycle = skip || (dif.op inside {OP_GOTO, OP_CALL, OP_RETLW}) ||
                  (file_wr && dif.faddr == SFR_PC_LOW);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core next state; execution results commit at the last quarter of a cycle, the queued word on its APB write
   always_comb begin
      logic [DATA_W-1:0] stat_v;
      stat_v = status_q;
      q_d = q_q + 2'h1;
      state_d = state_q;
      ir_d = ir_q;
      pend_d = pend_q;
      pend_ir_d = pend_ir_q;
      acc_d = acc_q;
      pc_d = pc_q;
      status_d = status_q;
      pc_latch_d = pc_latch_q;
      pdir_d = pdir_q;
      mem_we = 1'b0;
      if (instr_wr) begin
         pend_d = 1'b1;
         pend_ir_d = pwdata[INSTR_W-1:0];
      end
      if (q_q == Q_LAST) begin
         if (state_q == ST_EXEC) begin
            if (acc_wr) begin
               acc_d = alu.res;
            end
            if (file_wr && dif.faddr == SFR_STATUS) begin
               stat_v = alu.res;
            end
            if (flag_use[2]) stat_v[STAT_Z] = alu.z;
            if (flag_use[1]) stat_v[STAT_DCARRY] = alu.dcarry;
            if (flag_use[0]) stat_v[STAT_C] = alu.c;
            status_d = stat_v;
            pc_d = pc_q + 13'h0001;
            if (file_wr) begin
               unique case (dif.faddr)
                  SFR_STATUS: ;
                  SFR_PC_LOW: begin
                     pc_d = {pc_latch_q[LATCH_HI_W-1:0], alu.res};
                  end
                  SFR_PC_LATCH: pc_latch_d = alu.res;
                  SFR_PORT_DIR: pdir_d = alu.res | PORT_DIR_FIXED;
                  default: mem_we = 1'b1;
               endcase
            end
            if (dif.op inside {OP_GOTO, OP_CALL}) begin
               pc_d = {pc_latch_q[LATCH_PAGE_LSB +: PAGE_W], dif.k11};
            end
         end
         if (state_q == ST_EXEC && two_cycle) begin
            state_d = ST_NOP;
         end else if (pend_q) begin
            state_d = ST_EXEC;
            ir_d = pend_ir_q;
            pend_d = 1'b0;
         end else begin
            state_d = ST_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave; an instruction write waits while one is still queued
   always_comb begin
      mapped = paddr inside {REG_INSTR, REG_CORE, REG_ACC, REG_PC,
                             REG_STATUS, REG_PC_LATCH, REG_PORT_DIR};
      pready = ~(psel && pwrite && paddr == REG_INSTR && pend_q);
      pslverr = psel && penable && ~mapped;
      instr_wr = psel && penable && pwrite && pready &&
                 paddr == REG_INSTR;
      prdata = prdata_q;
      prdata_d = prdata_q;
      if (psel && !penable) begin
         unique case (paddr)
            REG_INSTR: prdata_d = {18'h00000, ir_q};
            REG_CORE: prdata_d = {28'h0000000, q_q, pend_q,
                                  state_q != ST_IDLE || pend_q};
            REG_ACC: prdata_d = {24'h000000, acc_q};
            REG_PC: prdata_d = {19'h00000, pc_q};
            REG_STATUS: prdata_d = {24'h000000, status_q};
            REG_PC_LATCH: prdata_d = {24'h000000, pc_latch_q};
            REG_PORT_DIR: prdata_d = {24'h000000, pdir_q | PORT_DIR_FIXED};
            default: prdata_d = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         q_q <= 2'h0;
         ir_q <= '0;
         pend_q <= 1'b0;
         pend_ir_q <= '0;
         acc_q <= ACC_RST;
         pc_q <= PC_RST;
         status_q <= STATUS_RST;
         pc_latch_q <= PC_LATCH_RST;
         pdir_q <= PORT_DIR_RST;
         prdata_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         q_q <= q_d;
         ir_q <= ir_d;
         pend_q <= pend_d;
         pend_ir_q <= pend_ir_d;
         acc_q <= acc_d;
         pc_q <= pc_d;
         status_q <= status_d;
         pc_latch_q <= pc_latch_d;
         pdir_q <= pdir_d;
         prdata_q <= prdata_d;
      end
   end
endmodule
`default_nettype wire

// ---- tb/instr_format_decode_exec_monitor.sv ----
/*
 Port checker for the decode and execute block.
 Assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none
module instr_format_decode_exec_monitor
   import core_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc_ph;
   logic mapped;
   logic rd_core;
   assign acc_ph = psel && penable;
   assign mapped = paddr inside {REG_INSTR, REG_CORE, REG_ACC, REG_PC,
      REG_STATUS, REG_PC_LATCH, REG_PORT_DIR};
   assign rd_core = acc_ph && !pwrite && paddr == REG_CORE;
   ////////////////////////////////////////////////////////////
   property p_err_unmapped;
      acc_ph && !mapped |-> pslverr && prdata == 32'h0;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("unmapped access without error or with data");
   property p_no_err_mapped;
      acc_ph && mapped |-> !pslverr;
   endproperty
   a_no_err_mapped: assert property (p_no_err_mapped)
      else $error("error flagged on a mapped address");
   property p_ready_other;
      psel && !(pwrite && paddr == REG_INSTR) |-> pready;
   endproperty
   a_ready_other: assert property (p_ready_other)
      else $error("wait state outside an instruction write");
   // Two-cycle op is the longest a queued word can wait
   property p_stall_bound;
      acc_ph && pwrite && paddr == REG_INSTR && !pready |-> ##[1:8] pready;
   endproperty
   a_stall_bound: assert property (p_stall_bound)
      else $error("instruction write stalled too long");
   property p_rdata_stands;
      !(psel && !penable) |=> $stable(prdata);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands)
      else $error("read data changed outside a setup cycle");
   property p_dir_bit3;
      acc_ph && !pwrite && paddr == REG_PORT_DIR |-> prdata[3];
   endproperty
   a_dir_bit3: assert property (p_dir_bit3)
      else $error("port direction bit 3 read as zero");
   property p_acc_width;
      acc_ph && !pwrite && paddr == REG_ACC |-> prdata[31:8] == 24'h0;
   endproperty
   a_acc_width: assert property (p_acc_width)
      else $error("accumulator wider than 8 bits");
   // Reads two clocks apart must see the quarter advance by two
   property p_quarter_step;
      rd_core ##2 rd_core |->
         prdata[3:2] == 2'($past(prdata[3:2], 2) + 2'h2);
   endproperty
   a_quarter_step: assert property (p_quarter_step)
      else $error("quarter counter not dividing by four");
   c_stall: cover property (acc_ph && !pready);
   c_unmapped: cover property (acc_ph && !mapped);
   c_core_b2b: cover property (rd_core ##2 rd_core);
endmodule
`default_nettype wire

// ---- tb/instr_format_decode_exec_tb.sv ----
/*
 Self-checking bench: feeds instructions over APB and reads results.
 Assumes the monitor file and the design files are compiled first.
*/
`default_nettype none
`define CHECK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("FAIL %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module instr_format_decode_exec_tb
   import core_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [13:0] t_ins [11] = '{14'h3000, 14'h2800, 14'h0fa1, 14'h0fa1,
      14'h18a1, 14'h1821, 14'h1c21, 14'h0ba1, 14'h2000, 14'h3477,
      14'h0082};
   int t_cyc [11] = '{4, 8, 8, 4, 8, 4, 8, 8, 8, 8, 8};
   instr_format_decode_exec u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   always #25 pclk = ~pclk;
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Ends right after the answering edge; request is not released
   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 40) begin
         n_fail++;
         $display("FAIL pready expected 1 seen 0");
      end
      rd = prdata;
      err = pslverr;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic e;
      xfer(1'b1, a, d, v, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      logic e;
      xfer(1'b0, a, 32'h0, v, e);
   endtask
   task automatic wait_idle;
      logic [31:0] v;
      int n;
      n = 0;
      v = 32'h1;
      while (v[0] !== 1'b0 && n < 40) begin
         rd(REG_CORE, v);
         n++;
      end
      `CHECK("core idle", 1'b0, v[0])
   endtask
   task automatic exec(input logic [13:0] i);
      wr(REG_INSTR, {18'h0, i});
      wait_idle();
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      `CHECK("register", e, v & m)
   endtask
   task automatic ex_acc(input logic [13:0] i, input logic [7:0] e);
      logic [31:0] v;
      exec(i);
      rd(REG_ACC, v);
      `CHECK("accumulator", e, v[7:0])
   endtask
   // Gap between the two trailing accepts equals the op's own length
   task automatic time_op(input logic [13:0] i, input int exp_cyc);
      int t1;
      wr(REG_INSTR, 32'h0);
      wr(REG_INSTR, {18'h0, i});
      wr(REG_INSTR, 32'h0);
      t1 = cyc;
      wr(REG_INSTR, 32'h0);
      `CHECK("cycles", exp_cyc, cyc - t1)
      wait_idle();
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      logic [31:0] v;
      logic e;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(REG_PORT_DIR, 32'hff, 32'hff);
      chk(REG_PC, 32'h1fff, 32'h0);
      xfer(1'b0, 12'h01c, 32'h0, v, e);
      `CHECK("pslverr", 1'b1, e)
      `CHECK("unmapped data", 32'h0, v)
      wr(REG_ACC, 32'hab);
      chk(REG_ACC, 32'hffffffff, {24'h0, ACC_RST});
      ex_acc(14'h335a, 8'h5a);
      chk(REG_PC, 32'h1fff, 32'h1);
      exec(14'h00a0);
      ex_acc(14'h0a20, 8'h5b);
      ex_acc(14'h0820, 8'h5a);
      exec(14'h0aa0);
      ex_acc(14'h0820, 8'h5b);
      ex_acc(14'h0060, 8'h5b);
      ex_acc(14'h3aff, 8'ha4);
      exec(14'h3001);
      exec(14'h00ff);
      exec(14'h17ff);
      exec(14'h107f);
      ex_acc(14'h087f, 8'h80);
      exec(14'h01a2);
      for (int b = 0; b < 8; b++) begin
         exec(14'h1422 | 14'(b << 7));
         ex_acc(14'h0822, 8'hff >> (7 - b));
      end
      for (int b = 0; b < 8; b++) begin
         exec(14'h1022 | 14'(b << 7));
         ex_acc(14'h0822, 8'(8'hff << (b + 1)));
      end
      // Zero flag left set by the last move of a zero byte
      ex_acc(14'h0803, STATUS_RST | 8'h04);
      exec(14'h0183);
      chk(REG_STATUS, 32'h7, 32'h4);
      ex_acc(14'h0803, 8'h04);
      exec(14'h3000);
      exec(14'h0086);
      ex_acc(14'h0806, 8'h08);
      exec(14'h1186);
      exec(14'h1406);
      ex_acc(14'h0806, 8'h09);
      chk(REG_PORT_DIR, 32'hff, 32'h09);
      exec(14'h3018);
      exec(14'h008a);
      chk(REG_PC_LATCH, 32'hff, 32'h18);
      exec(14'h2923);
      chk(REG_PC, 32'h1fff, 32'h1923);
      exec(14'h3040);
      exec(14'h0082);
      chk(REG_PC, 32'h1fff, 32'h1840);
      ex_acc(14'h0802, 8'h40);
      exec(14'h0a82);
      chk(REG_PC, 32'h1fff, 32'h1842);
      exec(14'h27ff);
      chk(REG_PC, 32'h1fff, 32'h1fff);
      // Add and subtract flags land in status
      exec(14'h300f);
      ex_acc(14'h3ef1, 8'h00);
      chk(REG_STATUS, 32'h7, 32'h7);
      ex_acc(14'h3c05, 8'h05);
      chk(REG_STATUS, 32'h7, 32'h3);
      ex_acc(14'h3830, 8'h35);
      ex_acc(14'h390f, 8'h05);
      exec(14'h00a3);
      ex_acc(14'h0e23, 8'h50);
      ex_acc(14'h0723, 8'h55);
      ex_acc(14'h0223, 8'hb0);
      ex_acc(14'h0623, 8'hb5);
      ex_acc(14'h0523, 8'h05);
      ex_acc(14'h0923, 8'hfa);
      ex_acc(14'h0423, 8'hff);
      ex_acc(14'h0323, 8'h04);
      // Rotates pass the carry through status
      ex_acc(14'h0c23, 8'h02);
      ex_acc(14'h0d23, 8'h0b);
      exec(14'h30ff);
      exec(14'h00a1);
      for (int k = 0; k < 11; k++) begin
         time_op(t_ins[k], t_cyc[k]);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      report_and_stop();
   end
endmodule
bind instr_format_decode_exec instr_format_decode_exec_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire
